// File: rtl/pll_serdes_trigger_config_bank.sv
`timescale 1ns/1ps
`include "pll_serdes_trigger_config_bank_regs.svh"

// How it works
// [RULE1] The third feedback divider lives in bits 5:0 and resets to 0x20.
// [RULE2] The feedback divider divides by exactly the field value, 1 to 63.
// [RULE3] The divider counts sampling-clock enables and emits feedback pulses.
// [RULE4] Software holds the synthesizer in reset before changing the ratio.
// [RULE5] Software writes reserved bits only with their reset value.
// [RULE6] The bias field is bits 6:0, resets to 0x4F, software writes 0x4A.
// [RULE7] One four-bit pre-emphasis value drives all serial lanes alike.
// [RULE8] Trigger enable bit 7 turns the trigger buffer and divider on or off.
// [RULE9] Trigger select 0..3 picks 16, 32, 64 UI clocks or the timestamp.
// [RULE10] Software changes the trigger select only while it is disabled.
// [RULE11] Select codes 0..2 follow the serializer and stop on its re-init.
// [RULE12] The pin-override register resets to zero with the given fields.
// [RULE13] Override enable picks register fields over configuration pins.
// [RULE14] A reserved trigger select code leaves the trigger output idle.
module pll_serdes_trigger_config_bank
(
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Configuration serial port pins.
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sdi,
  output logic            o_spi_sdo,
  output logic            o_spi_sdo_oe,
  // Synthesizer feedback path.
  input  wire logic       i_sample_en,
  input  wire logic       i_synth_hold_in_reset,
  output logic            o_fb_pulse,
  output logic [5:0]      o_fbdiv_ratio,
  output logic [6:0]      o_oscillator_bias_level,
  // Serial lanes and trigger output.
  output logic [3:0]      o_lane_preemphasis_level,
  input  wire logic       i_ui_en,
  input  wire logic       i_ser_reinit,
  input  wire logic       i_timestamp_input,
  output logic            o_trigger_out_enable,
  output logic            o_trigger_output,
  // Synthesizer configuration pins and resolved controls.
  input  wire logic       i_pin_synth_en,
  input  wire logic       i_pin_single_ended_ref,
  input  wire logic [1:0] i_pin_clk_cfg,
  output logic            o_synth_enable,
  output logic            o_single_ended_ref,
  output logic [1:0]      o_first_divided_ref_mode,
  output logic [1:0]      o_second_divided_ref_mode
);

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic       sclk_d_reg;
  wire  [7:0] pins_raw = {i_spi_sclk, i_spi_cs_n, i_spi_sdi, i_timestamp_input,
                          i_pin_synth_en, i_pin_single_ended_ref, i_pin_clk_cfg};
  wire        sclk_s   = sync2_reg[7];
  wire        cs_n_s   = sync2_reg[6];
  wire        sdi_s    = sync2_reg[5];
  wire        ts_s     = sync2_reg[4];
  wire        pin_en_s = sync2_reg[3];
  wire        pin_se_s = sync2_reg[2];
  wire  [1:0] pin_cfg_s = sync2_reg[1:0];
  wire        sclk_rise = sclk_s & ~sclk_d_reg;
  wire        sclk_fall = ~sclk_s & sclk_d_reg;

  // Two flops per pin; only the second stage is looked at.
  always_ff @(posedge i_clk)
  begin
    sync1_reg  <= pins_raw;
    sync2_reg  <= sync1_reg;
    sclk_d_reg <= sclk_s;
  end

  // ----------------------------------------------------------------------
  // Serial frame: read flag, 15-bit address, 8 data bits, MSB first.
  // ----------------------------------------------------------------------
  pll_serdes_trigger_config_bank_pkg::spi_state_t state_reg;
  logic [22:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic [7:0]  rd_shift_reg;
  logic        rd_frame_reg;
  logic [7:0] fbdiv_reg;
  logic [7:0] bias_reg;
  logic [7:0] emph_reg;
  pll_serdes_trigger_config_bank_pkg::trig_cfg_t trig_reg;
  pll_serdes_trigger_config_bank_pkg::pin_ovr_t  ovr_reg;
  wire [15:0] cmd_now  = {shift_reg[14:0], sdi_s};
  wire [14:0] cmd_addr = cmd_now[14:0];
  wire        cmd_done = sclk_rise && bit_cnt_reg == `SPI_CMD_BITS - 5'h01;
  wire        wr_en    = sclk_rise && bit_cnt_reg == `SPI_LAST_BIT
                         && !shift_reg[22] && state_reg ==
                         pll_serdes_trigger_config_bank_pkg::SPI_SHIFT;
  wire [14:0] wr_addr  = shift_reg[21:7];
  wire [7:0]  wr_data  = {shift_reg[6:0], sdi_s};
  wire        data_ph  = bit_cnt_reg >= `SPI_CMD_BITS;
  // Unmapped addresses read as zero; writes to them are dropped.
  wire [7:0] rd_data =
    (cmd_addr == `FBDIV_N_OFFSET)   ? fbdiv_reg :
    (cmd_addr == `OSC_BIAS_OFFSET)  ? bias_reg  :
    (cmd_addr == `LANE_EMPH_OFFSET) ? emph_reg  :
    (cmd_addr == `TRIG_CFG_OFFSET)  ? trig_reg  :
    (cmd_addr == `PIN_OVR_OFFSET)   ? ovr_reg   : 8'h00;
  // Frame sequencer; chip select high aborts any partial frame.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || cs_n_s)
    begin
      state_reg    <= pll_serdes_trigger_config_bank_pkg::SPI_IDLE;
      bit_cnt_reg  <= 5'h00;
      rd_frame_reg <= 1'b0;
    end
    else if (sclk_rise)
    begin
      state_reg    <= pll_serdes_trigger_config_bank_pkg::SPI_SHIFT;
      shift_reg    <= {shift_reg[21:0], sdi_s};
      bit_cnt_reg  <= (bit_cnt_reg == `SPI_LAST_BIT) ? 5'h00
                                                      : bit_cnt_reg + 5'h01;
      if (cmd_done)
        rd_frame_reg <= cmd_now[15];
    end
  end
  // Read data leaves on falling edges so the master samples it on rising.
  // The read byte is loaded here too, so one process owns the shifter.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || cs_n_s)
    begin
      o_spi_sdo    <= 1'b0;
      o_spi_sdo_oe <= 1'b0;
    end
    else if (sclk_fall && data_ph && rd_frame_reg)
    begin
      o_spi_sdo    <= rd_shift_reg[7];
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      o_spi_sdo_oe <= 1'b1;
    end
    else if (cmd_done)
      rd_shift_reg <= rd_data;
  end

  // ----------------------------------------------------------------------
  // Register bank. Reserved bits are stored as written.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      fbdiv_reg <= `FBDIV_N_RESET;   // [RULE1]
      bias_reg  <= `OSC_BIAS_RESET;  // [RULE6]
      emph_reg  <= `LANE_EMPH_RESET;
      trig_reg  <= `TRIG_CFG_RESET;  // [RULE8]
      ovr_reg   <= `PIN_OVR_RESET;   // [RULE12]
    end
    else if (wr_en)
    begin
      if (wr_addr == `FBDIV_N_OFFSET)   fbdiv_reg <= wr_data;
      if (wr_addr == `OSC_BIAS_OFFSET)  bias_reg  <= wr_data;
      if (wr_addr == `LANE_EMPH_OFFSET) emph_reg  <= wr_data;
      if (wr_addr == `TRIG_CFG_OFFSET)  trig_reg  <= wr_data;
      if (wr_addr == `PIN_OVR_OFFSET)   ovr_reg   <= wr_data;
    end
  end
  // Field outputs are register slices, so they come straight from flops.
  assign o_fbdiv_ratio            = fbdiv_reg[`FBDIV_N_MSB:0];   // [RULE1]
  assign o_oscillator_bias_level  = bias_reg[`OSC_BIAS_MSB:0];   // [RULE6]
  assign o_lane_preemphasis_level = emph_reg[`LANE_EMPH_MSB:0];  // [RULE7]
  assign o_trigger_out_enable     = trig_reg.en;                 // [RULE8]

  // ----------------------------------------------------------------------
  // Third feedback divider on the sampling-clock enable.
  // ----------------------------------------------------------------------
  logic [5:0] fb_cnt_reg;
  wire  [5:0] fb_ratio = fbdiv_reg[`FBDIV_N_MSB:0];
  wire        fb_wrap  = fb_cnt_reg >= fb_ratio - 6'h01;
  // A ratio of zero is unsupported and simply produces no pulses.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_synth_hold_in_reset)  // [RULE4]
    begin
      fb_cnt_reg <= 6'h00;
      o_fb_pulse <= 1'b0;
    end
    else
    begin
      o_fb_pulse <= i_sample_en && fb_wrap && fb_ratio != 6'h00;  // [RULE2]
      if (i_sample_en)                                            // [RULE3]
        fb_cnt_reg <= fb_wrap ? 6'h00 : fb_cnt_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger output: divided UI clock or resampled timestamp.
  // ----------------------------------------------------------------------
  logic [4:0] trig_cnt_reg;
  logic       trig_lvl_reg;
  wire        sel_div  = trig_reg.sel < `TRIG_SEL_TS;
  wire [4:0]  half_cnt = (trig_reg.sel == 3'h0) ? `TRIG_HALF_16UI :
                         (trig_reg.sel == 3'h1) ? `TRIG_HALF_32UI :
                                                  `TRIG_HALF_64UI;  // [RULE9]
  wire        div_run  = trig_reg.en && sel_div && !i_ser_reinit;  // [RULE11]
  wire        trig_next =
    !trig_reg.en                    ? 1'b0 :          // [RULE8]
    div_run                         ? trig_lvl_reg :
    trig_reg.sel == `TRIG_SEL_TS    ? ts_s : 1'b0;     // [RULE9] [RULE14]
  // Serializer re-init restarts the divider, briefly breaking the waveform.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !div_run)
    begin
      trig_cnt_reg <= 5'h00;
      trig_lvl_reg <= 1'b0;
    end
    else if (i_ui_en)
    begin
      trig_cnt_reg <= (trig_cnt_reg >= half_cnt) ? 5'h00
                                                 : trig_cnt_reg + 5'h01;
      if (trig_cnt_reg >= half_cnt)
        trig_lvl_reg <= ~trig_lvl_reg;
    end
  end

  // The pin level is re-registered so the output leaves a flop directly.
  always_ff @(posedge i_clk)
  begin
    o_trigger_output <= i_rst ? 1'b0 : trig_next;
  end

  // ----------------------------------------------------------------------
  // Synthesizer control: pins unless the override is enabled.
  // ----------------------------------------------------------------------
  // Pin mode feeds both divided-ref modes from the clock-config pins.
  wire [5:0] synth_sel = ovr_reg.en  // [RULE13]
    ? {ovr_reg.synth_en, ovr_reg.se_ref, ovr_reg.first_mode,
       ovr_reg.second_mode}
    : {pin_en_s, pin_se_s, pin_cfg_s, pin_cfg_s};
  // Registered so the resolved controls leave the block from flops.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      {o_synth_enable, o_single_ended_ref, o_first_divided_ref_mode,
       o_second_divided_ref_mode} <= 6'h00;
    else
      {o_synth_enable, o_single_ended_ref, o_first_divided_ref_mode,
       o_second_divided_ref_mode} <= synth_sel;
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  a_fbdiv_reset_val: assert property (  // [RULE1]
    @(posedge i_clk) $past(i_rst) |-> fbdiv_reg == `FBDIV_N_RESET)
    else $error("feedback divider reset value wrong");
  a_fb_pulse_gap: assert property (  // [RULE2]
    @(posedge i_clk) disable iff (i_rst)
    (o_fb_pulse && fb_ratio > 6'h01 && !wr_en) |=> !o_fb_pulse)
    else $error("feedback pulses too close");
  a_fb_hold_quiet: assert property (  // [RULE4]
    @(posedge i_clk) disable iff (i_rst)
    i_synth_hold_in_reset |=> !o_fb_pulse)
    else $error("feedback pulse while held in reset");
  a_emph_write: assert property (  // [RULE7]
    @(posedge i_clk) disable iff (i_rst)
    (wr_en && wr_addr == `LANE_EMPH_OFFSET)
      |=> o_lane_preemphasis_level == $past(wr_data[3:0]))
    else $error("pre-emphasis write lost");
  a_trig_off_low: assert property (  // [RULE8]
    @(posedge i_clk) disable iff (i_rst)
    !trig_reg.en |=> !o_trigger_output)
    else $error("trigger toggles while disabled");
  a_trig_ts_follow: assert property (  // [RULE9]
    @(posedge i_clk) disable iff (i_rst)
    (trig_reg.en && trig_reg.sel == `TRIG_SEL_TS)
      |=> o_trigger_output == $past(ts_s))
    else $error("timestamp not resampled to trigger");
  a_trig_reinit_low: assert property (  // [RULE11]
    @(posedge i_clk) disable iff (i_rst)
    (i_ser_reinit && sel_div) |=> !o_trigger_output)
    else $error("trigger runs during serializer re-init");
  a_trig_rsv_idle: assert property (  // [RULE14]
    @(posedge i_clk) disable iff (i_rst)
    (trig_reg.sel > `TRIG_SEL_TS) |=> !o_trigger_output)
    else $error("reserved trigger select toggles");
  a_ovr_reg_wins: assert property (  // [RULE13]
    @(posedge i_clk) disable iff (i_rst)
    ovr_reg.en |=> o_synth_enable == $past(ovr_reg.synth_en))
    else $error("override enable ignored");
  a_ovr_pin_path: assert property (  // [RULE13]
    @(posedge i_clk) disable iff (i_rst)
    !ovr_reg.en |=> o_synth_enable == $past(pin_en_s))
    else $error("pin mode ignored");
endmodule

// File: rtl/pll_serdes_trigger_config_bank_pkg.sv
package pll_serdes_trigger_config_bank_pkg;

  // Trigger-output control layout.
  typedef struct packed {
    logic       en;
    logic [3:0] rsv;
    logic [2:0] sel;
  } trig_cfg_t;

  // Synthesizer pin-override layout.
  typedef struct packed {
    logic       en;
    logic       rsv;
    logic [1:0] second_mode;
    logic [1:0] first_mode;
    logic       se_ref;
    logic       synth_en;
  } pin_ovr_t;

  // Serial port frame state.
  typedef enum logic {
    SPI_IDLE,
    SPI_SHIFT
  } spi_state_t;

endpackage

// File: rtl/pll_serdes_trigger_config_bank_regs.svh
`ifndef PLL_SERDES_TRIGGER_CONFIG_BANK_REGS_SVH
`define PLL_SERDES_TRIGGER_CONFIG_BANK_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets on the configuration serial port.
// ----------------------------------------------------------------------
`define FBDIV_N_OFFSET   15'h003e
`define OSC_BIAS_OFFSET  15'h003f
`define LANE_EMPH_OFFSET 15'h0048
`define TRIG_CFG_OFFSET  15'h0057
`define PIN_OVR_OFFSET   15'h0058

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define FBDIV_N_RESET    8'h20
`define OSC_BIAS_RESET   8'h4f
`define LANE_EMPH_RESET  8'h00
`define TRIG_CFG_RESET   8'h00
`define PIN_OVR_RESET    8'h00

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define FBDIV_N_MSB      5
`define OSC_BIAS_MSB     6
`define LANE_EMPH_MSB    3

// ----------------------------------------------------------------------
// Serial frame layout and trigger half-period terminal counts, one UI less than each half period.
// ----------------------------------------------------------------------
`define SPI_CMD_BITS     5'h10
`define SPI_LAST_BIT     5'h17
`define TRIG_SEL_TS      3'h3
`define TRIG_HALF_16UI   5'h07
`define TRIG_HALF_32UI   5'h0f
`define TRIG_HALF_64UI   5'h1f

`endif

// File: sim/pll_serdes_trigger_config_bank_tb.sv
`timescale 1ns/1ps
`include "pll_serdes_trigger_config_bank_regs.svh"

// Counts every comparison and reports a mismatch at once.
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("BAD t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

module pll_serdes_trigger_config_bank_tb;
  // ----------------------------------------------------------------------
  // Stimulus, observed outputs and bookkeeping.
  // ----------------------------------------------------------------------
  logic       i_clk, i_rst, i_spi_sclk, i_spi_cs_n, i_spi_sdi, i_sample_en;
  logic       i_synth_hold_in_reset, i_ui_en, i_ser_reinit;
  logic       i_timestamp_input, i_pin_synth_en, i_pin_single_ended_ref;
  logic [1:0] i_pin_clk_cfg, o_first_divided_ref_mode;
  logic [1:0] o_second_divided_ref_mode;
  logic       o_spi_sdo, o_spi_sdo_oe, o_fb_pulse, o_trigger_out_enable;
  logic       o_trigger_output, o_synth_enable, o_single_ended_ref;
  logic [5:0] o_fbdiv_ratio;
  logic [6:0] o_oscillator_bias_level;
  logic [3:0] o_lane_preemphasis_level;
  logic [7:0] rd_q;
  logic       trig_last, oe_q;
  int         num_errors, checks, fb_cnt, trig_tg;

  pll_serdes_trigger_config_bank pll_serdes_trigger_config_bank_inst (
    .i_clk, .i_rst, .i_spi_sclk, .i_spi_cs_n, .i_spi_sdi, .o_spi_sdo,
    .o_spi_sdo_oe, .i_sample_en, .i_synth_hold_in_reset, .o_fb_pulse,
    .o_fbdiv_ratio, .o_oscillator_bias_level, .o_lane_preemphasis_level,
    .i_ui_en, .i_ser_reinit, .i_timestamp_input, .o_trigger_out_enable,
    .o_trigger_output, .i_pin_synth_en, .i_pin_single_ended_ref,
    .i_pin_clk_cfg, .o_synth_enable, .o_single_ended_ref,
    .o_first_divided_ref_mode, .o_second_divided_ref_mode);

  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  // n cycles; inputs change 1 ns after each edge, so the design never
  // sees them race its own sampling edge. Pulses and edges are counted.
  task automatic step(input int n = 1);
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
      if (o_fb_pulse === 1'b1) fb_cnt++;
      if (o_trigger_output !== trig_last) trig_tg++;
      trig_last = o_trigger_output;
    end
  endtask

  // Whole 24-bit frame; sclk phases last 5 cycles, above the 3 required.
  task automatic xfer(input logic rd, input logic [14:0] a,
                      input logic [7:0] d);
    logic [23:0] w;
    w = {rd, a, d};
    i_spi_cs_n = 1'b0;
    step(5);
    for (int i = 23; i >= 0; i--)
    begin
      i_spi_sclk = 1'b0;
      i_spi_sdi = w[i];
      step(5);
      if (i < 8) rd_q = {rd_q[6:0], o_spi_sdo};
      if (i == 0) oe_q = o_spi_sdo_oe;
      i_spi_sclk = 1'b1;
      step(5);
    end
    i_spi_sclk = 1'b0;
    step(5);
    i_spi_cs_n = 1'b1;
    step(5);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    `CHK(rd_q, e)
    `CHK(oe_q, 1'b1)
  endtask

  // Single-cycle enables with a gap, on either the sample or UI strobe.
  task automatic en_pulses(input int n, input bit ui);
    repeat (n)
    begin
      if (ui) i_ui_en = 1'b1;
      else i_sample_en = 1'b1;
      step(1);
      i_ui_en = 1'b0;
      i_sample_en = 1'b0;
      step(1);
    end
  endtask

  task automatic close_out;
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic reset_values;
    `CHK(o_fbdiv_ratio, 6'h20)
    `CHK(o_oscillator_bias_level, 7'h4f)
    `CHK(o_trigger_out_enable, 1'b0)
    rd_chk(`FBDIV_N_OFFSET, 8'h20);
    rd_chk(`OSC_BIAS_OFFSET, 8'h4f);
    rd_chk(`LANE_EMPH_OFFSET, 8'h00);
    rd_chk(`TRIG_CFG_OFFSET, 8'h00);
    rd_chk(`PIN_OVR_OFFSET, 8'h00);
  endtask

  // Reserved bits are always written as zero; an unmapped place reads 0.
  task automatic reg_access;
    wr(`OSC_BIAS_OFFSET, 8'h4a);
    `CHK(o_oscillator_bias_level, 7'h4a)
    wr(`LANE_EMPH_OFFSET, 8'h0b);
    `CHK(o_lane_preemphasis_level, 4'hb)
    rd_chk(`LANE_EMPH_OFFSET, 8'h0b);
    wr(15'h0040, 8'h5a);
    rd_chk(15'h0040, 8'h00);
    `CHK(o_oscillator_bias_level, 7'h4a)
  endtask

  // Ratio changes only with the synthesizer held; 1 and 63 are the ends.
  task automatic fbdiv_run(input logic [5:0] n, input int en, input int exp);
    i_synth_hold_in_reset = 1'b1;
    wr(`FBDIV_N_OFFSET, {2'b00, n});
    `CHK(o_fbdiv_ratio, n)
    fb_cnt = 0;
    en_pulses(6, 0);
    `CHK(fb_cnt, 0)
    i_synth_hold_in_reset = 1'b0;
    step(2);
    fb_cnt = 0;
    en_pulses(en, 0);
    step(3);
    `CHK(fb_cnt, exp)
  endtask

  task automatic trig_modes;
    for (int s = 0; s < 3; s++)
    begin
      wr(`TRIG_CFG_OFFSET, {5'h00, s[2:0]});
      wr(`TRIG_CFG_OFFSET, {5'h10, s[2:0]});
      `CHK(o_trigger_out_enable, 1'b1)
      i_ser_reinit = 1'b1;
      step(1);
      i_ser_reinit = 1'b0;
      step(2);
      trig_tg = 0;
      en_pulses(64, 1);
      step(3);
      `CHK(trig_tg, 8 >> s)
      `CHK(o_trigger_output, 1'b0)
      wr(`TRIG_CFG_OFFSET, {5'h00, s[2:0]});
    end
    // Re-initialising the serializer mid-waveform drops the output.
    wr(`TRIG_CFG_OFFSET, 8'h00);
    wr(`TRIG_CFG_OFFSET, 8'h80);
    en_pulses(8, 1);
    step(2);
    `CHK(o_trigger_output, 1'b1)
    i_ser_reinit = 1'b1;
    step(2);
    `CHK(o_trigger_output, 1'b0)
    trig_tg = 0;
    en_pulses(16, 1);
    `CHK(trig_tg, 0)
    i_ser_reinit = 1'b0;
    wr(`TRIG_CFG_OFFSET, 8'h00);
    trig_tg = 0;
    en_pulses(32, 1);
    `CHK(trig_tg, 0)
    // Timestamp pass-through, then every reserved code stays quiet.
    wr(`TRIG_CFG_OFFSET, 8'h03);
    wr(`TRIG_CFG_OFFSET, 8'h83);
    i_timestamp_input = 1'b1;
    step(6);
    `CHK(o_trigger_output, 1'b1)
    i_timestamp_input = 1'b0;
    step(6);
    `CHK(o_trigger_output, 1'b0)
    wr(`TRIG_CFG_OFFSET, 8'h03);
    for (int s = 4; s < 8; s++)
    begin
      wr(`TRIG_CFG_OFFSET, {5'h00, s[2:0]});
      wr(`TRIG_CFG_OFFSET, {5'h10, s[2:0]});
      trig_tg = 0;
      i_timestamp_input = 1'b1;
      en_pulses(20, 1);
      i_timestamp_input = 1'b0;
      step(4);
      `CHK(trig_tg, 0)
      wr(`TRIG_CFG_OFFSET, {5'h00, s[2:0]});
    end
  endtask

  task automatic overrides;
    i_pin_synth_en = 1'b1;
    i_pin_clk_cfg = 2'b10;
    step(6);
    `CHK({o_synth_enable, o_single_ended_ref}, 2'b10)
    `CHK({o_first_divided_ref_mode, o_second_divided_ref_mode}, 4'ha)
    wr(`PIN_OVR_OFFSET, 8'h9e);
    `CHK({o_synth_enable, o_single_ended_ref}, 2'b01)
    `CHK({o_first_divided_ref_mode, o_second_divided_ref_mode}, 4'hd)
    rd_chk(`PIN_OVR_OFFSET, 8'h9e);
    wr(`PIN_OVR_OFFSET, 8'h00);
    `CHK({o_synth_enable, o_first_divided_ref_mode}, 3'b110)
  endtask

  // ----------------------------------------------------------------------
  // Clock, main sequence and hang guard.
  // ----------------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial
  begin
    {i_spi_sclk, i_spi_sdi, i_sample_en, i_synth_hold_in_reset} = 4'h0;
    {i_ui_en, i_ser_reinit, i_timestamp_input, i_pin_synth_en} = 4'h0;
    i_pin_single_ended_ref = 1'b0;
    i_pin_clk_cfg = 2'b00;
    i_spi_cs_n = 1'b1;
    i_rst = 1'b1;
    trig_last = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    step(2);
    reset_values();
    reg_access();
    fbdiv_run(6'h03, 9, 3);
    fbdiv_run(6'h01, 5, 5);
    fbdiv_run(6'h3f, 126, 2);
    trig_modes();
    overrides();
    close_out();
  end

  // A hang is cut short and counted as a mismatch.
  initial
  begin
    repeat (90000) @(posedge i_clk);
    num_errors++;
    close_out();
  end
endmodule
